// *** core/charger_cfg_consts.svh ***
// Overview of operation
// - Restart bit: 140 mV or 240 mV below
// - Regulation voltage bits 5:0 reset 011110
// - 20 mV steps from 3.60 V, clamped 32h
// - Registers 15h and 16h obey write lock
// - Bit 7 of 16h selects thermistor, reset 1
// - Bit 6 of 16h doubles safety timers
// - Fast timer 3/5/7/9 h, reset 01
// - Prequal timer bits 3:2, 15..60 min, reset 01
// - Beta select bits 7:5 of 17h, reset 001
// - Beta codes map 3434 through 4750
// - Thermal threshold bits 2:0 of 17h, reset 100
// - Thermal codes select 80 to 115 C
`ifndef CHARGER_CFG_CONSTS_SVH
`define CHARGER_CFG_CONSTS_SVH
`define CFG_ADDR_VOLT 8'h15
`define CFG_ADDR_TIMER 8'h16
`define CFG_ADDR_THERM 8'h17
`define CFG_RST_VOLT 8'h1E
`define CFG_RST_TIMER 8'h95
`define CFG_RST_THERM 8'h24
`define CFG_VREG_MAX_CODE 6'h32
`define CFG_VREG_BASE_MV 16'h0E10
`define CFG_VREG_STEP_MV 16'h0014
`define CFG_RESTART_LO_MV 16'h008C
`define CFG_RESTART_HI_MV 16'h00F0
`define CFG_THERM_BASE_C 8'h50
`define CFG_THERM_STEP_C 8'h05
`endif

// *** core/charger_cfg_pkg.sv ***
package charger_cfg_pkg;
  typedef struct packed {
    logic we;
    logic re;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;
  typedef struct packed {
    logic thermistor_resistance_select;
    logic safety_timer_double;
    logic [1:0] fast_charge_timer;
    logic [1:0] prequal_charge_timer;
    logic [1:0] topoff_timer;
  } timer_fields_t;
  typedef struct packed {
    logic [15:0] vreg_mv;
    logic [15:0] restart_mv;
    logic [11:0] fast_min;
    logic [7:0] prequal_min;
    logic [7:0] topoff_tenth_min;
    logic [15:0] beta;
    logic [7:0] therm_c;
    logic [6:0] therm_ua;
  } charger_setpoints_t;
endpackage

// *** core/charger_setpoint_decode.sv ***
`timescale 1ns/1ps
`include "charger_cfg_consts.svh"
module charger_setpoint_decode (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [7:0] volt_reg,
  input wire charger_cfg_pkg::timer_fields_t timer_reg,
  input wire logic [7:0] therm_reg,
  output charger_cfg_pkg::charger_setpoints_t setpoints_q
);
  charger_cfg_pkg::charger_setpoints_t setpoints_d;
  logic [5:0] code;
  logic [11:0] fast_h;
  logic [7:0] preq;

  function automatic logic [15:0] beta_of(input logic [2:0] sel);
    case (sel)
      3'h0: beta_of = 16'h0D6A;
      3'h1: beta_of = 16'h0E1A;
      3'h2: beta_of = 16'h0F5E;
      3'h3: beta_of = 16'h0F6E;
      3'h4: beta_of = 16'h1004;
      3'h5: beta_of = 16'h10D7;
      3'h6: beta_of = 16'h11BF;
      default: beta_of = 16'h128E;
    endcase
  endfunction

  always_comb
  begin
    setpoints_d = '0;
    code = (volt_reg[5:0] > `CFG_VREG_MAX_CODE) ? `CFG_VREG_MAX_CODE : volt_reg[5:0];
    setpoints_d.vreg_mv = `CFG_VREG_BASE_MV + 16'(code) * `CFG_VREG_STEP_MV;
    setpoints_d.restart_mv = setpoints_d.vreg_mv -
      (volt_reg[6] ? `CFG_RESTART_HI_MV : `CFG_RESTART_LO_MV);
    fast_h = 12'(3 + 2 * 32'(timer_reg.fast_charge_timer)) * 12'h03C;
    preq = 8'h0F * 8'(32'(timer_reg.prequal_charge_timer) + 1);
    setpoints_d.fast_min = timer_reg.safety_timer_double ? 12'(fast_h << 1) : fast_h;
    setpoints_d.prequal_min = timer_reg.safety_timer_double ? 8'(preq << 1) : preq;
    setpoints_d.topoff_tenth_min = 8'h40 * 8'(timer_reg.topoff_timer);
    setpoints_d.beta = beta_of(therm_reg[7:5]);
    setpoints_d.therm_c = `CFG_THERM_BASE_C + `CFG_THERM_STEP_C * 8'(therm_reg[2:0]);
    setpoints_d.therm_ua = timer_reg.thermistor_resistance_select ? 7'h32 : 7'h05;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      setpoints_q <= '0;
    else
      setpoints_q <= setpoints_d;
  end
endmodule // charger_setpoint_decode

// *** core/charger_config_registers.sv ***
`timescale 1ns/1ps
`include "charger_cfg_consts.svh"
module charger_config_registers (
  input wire logic clk_sys,
  input wire logic rst,
  input wire charger_cfg_pkg::reg_req_t req,
  input wire logic charger_write_lock,
  output logic [7:0] rdata_q,
  output logic rvalid_q,
  output logic [7:0] volt_ctl_q,
  output charger_cfg_pkg::timer_fields_t timer_ctl_q,
  output logic [7:0] therm_ctl_q,
  output charger_cfg_pkg::charger_setpoints_t setpoints_q
);
  ////////////////////////////////////////////////////////////////////////////
  // Register writes
  logic wr_volt;
  logic wr_timer;
  logic wr_therm;

  assign wr_volt = req.we && req.addr == `CFG_ADDR_VOLT && !charger_write_lock;
  assign wr_timer = req.we && req.addr == `CFG_ADDR_TIMER && !charger_write_lock;
  assign wr_therm = req.we && req.addr == `CFG_ADDR_THERM;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      volt_ctl_q <= `CFG_RST_VOLT;
    else if (wr_volt)
      volt_ctl_q <= req.wdata;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      timer_ctl_q <= `CFG_RST_TIMER;
    else if (wr_timer)
      timer_ctl_q <= req.wdata;
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      therm_ctl_q <= `CFG_RST_THERM;
    else if (wr_therm)
      therm_ctl_q <= req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Readback; unmapped addresses read zero
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rvalid_q <= req.re;
      if (req.re)
        case (req.addr)
          `CFG_ADDR_VOLT: rdata_q <= volt_ctl_q;
          `CFG_ADDR_TIMER: rdata_q <= timer_ctl_q;
          `CFG_ADDR_THERM: rdata_q <= therm_ctl_q;
          default: rdata_q <= 8'h00;
        endcase
    end
  end

  charger_setpoint_decode u_decode (
    .clk_sys(clk_sys),
    .rst(rst),
    .volt_reg(volt_ctl_q),
    .timer_reg(timer_ctl_q),
    .therm_reg(therm_ctl_q),
    .setpoints_q(setpoints_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_lock_holds_volt;
    @(posedge clk_sys) disable iff (rst)
    (charger_write_lock && req.we && req.addr == `CFG_ADDR_VOLT) |=> $stable(volt_ctl_q);
  endproperty
  a_lock_holds_volt: assert property (p_lock_holds_volt) else $error("locked volt write took");

  property p_lock_holds_timer;
    @(posedge clk_sys) disable iff (rst)
    (charger_write_lock && req.we && req.addr == `CFG_ADDR_TIMER) |=> $stable(timer_ctl_q);
  endproperty
  a_lock_holds_timer: assert property (p_lock_holds_timer) else $error("locked timer write took");

  property p_therm_ignores_lock;
    @(posedge clk_sys) disable iff (rst)
    (req.we && req.addr == `CFG_ADDR_THERM) |=> therm_ctl_q == $past(req.wdata);
  endproperty
  a_therm_ignores_lock: assert property (p_therm_ignores_lock) else $error("therm write lost");

  property p_volt_write;
    @(posedge clk_sys) disable iff (rst)
    (!charger_write_lock && req.we && req.addr == `CFG_ADDR_VOLT) |=> volt_ctl_q == $past(req.wdata);
  endproperty
  a_volt_write: assert property (p_volt_write) else $error("volt write lost");

  property p_vreg_clamp;
    @(posedge clk_sys) disable iff (rst)
    (volt_ctl_q[5:0] >= `CFG_VREG_MAX_CODE) [*2] |-> setpoints_q.vreg_mv == 16'h11F8;
  endproperty
  a_vreg_clamp: assert property (p_vreg_clamp) else $error("voltage clamp wrong");

  property p_restart_gap;
    @(posedge clk_sys) disable iff (rst)
    $stable(volt_ctl_q) |=>
      setpoints_q.vreg_mv - setpoints_q.restart_mv == ($past(volt_ctl_q[6]) ? 16'h00F0 : 16'h008C);
  endproperty
  a_restart_gap: assert property (p_restart_gap) else $error("restart gap wrong");

  property p_double_timer;
    @(posedge clk_sys) disable iff (rst)
    (timer_ctl_q.safety_timer_double && timer_ctl_q.prequal_charge_timer == 2'h0) [*2]
      |-> setpoints_q.prequal_min == 8'h1E;
  endproperty
  a_double_timer: assert property (p_double_timer) else $error("doubled prequal wrong");

  property p_therm_range;
    @(posedge clk_sys) disable iff (rst)
    ##1 (setpoints_q.therm_c >= 8'h50 && setpoints_q.therm_c <= 8'h73) || $past(rst);
  endproperty
  a_therm_range: assert property (p_therm_range) else $error("thermal threshold range");

  property p_read_answer;
    @(posedge clk_sys) disable iff (rst)
    (req.re && req.addr == `CFG_ADDR_TIMER) |=> rvalid_q && rdata_q == $past(timer_ctl_q);
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("timer readback wrong");

  property p_timer_write;
    @(posedge clk_sys) disable iff (rst)
    (!charger_write_lock && req.we && req.addr == `CFG_ADDR_TIMER) |=> timer_ctl_q == $past(req.wdata);
  endproperty
  a_timer_write: assert property (p_timer_write) else $error("timer write lost");

  property p_volt_only_by_write;
    @(posedge clk_sys) disable iff (rst)
    !(req.we && !charger_write_lock && req.addr == `CFG_ADDR_VOLT) |=> $stable(volt_ctl_q);
  endproperty
  a_volt_only_by_write: assert property (p_volt_only_by_write) else $error("volt changed without write");

  property p_timer_only_by_write;
    @(posedge clk_sys) disable iff (rst)
    !(req.we && !charger_write_lock && req.addr == `CFG_ADDR_TIMER) |=> $stable(timer_ctl_q);
  endproperty
  a_timer_only_by_write: assert property (p_timer_only_by_write) else $error("timer changed without write");

  property p_therm_only_by_write;
    @(posedge clk_sys) disable iff (rst)
    !(req.we && req.addr == `CFG_ADDR_THERM) |=> $stable(therm_ctl_q);
  endproperty
  a_therm_only_by_write: assert property (p_therm_only_by_write) else $error("therm changed without write");

  property p_reset_volt;
    @(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> volt_ctl_q == 8'h1E;
  endproperty
  a_reset_volt: assert property (p_reset_volt) else $error("volt reset value wrong");

  property p_reset_timer;
    @(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> timer_ctl_q == 8'h95;
  endproperty
  a_reset_timer: assert property (p_reset_timer) else $error("timer reset value wrong");

  property p_reset_therm;
    @(posedge clk_sys) disable iff (rst)
    $fell(rst) |-> therm_ctl_q == 8'h24;
  endproperty
  a_reset_therm: assert property (p_reset_therm) else $error("therm reset value wrong");

  property p_rvalid_pulse;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> rvalid_q == $past(req.re);
  endproperty
  a_rvalid_pulse: assert property (p_rvalid_pulse) else $error("read valid timing wrong");

  property p_read_volt;
    @(posedge clk_sys) disable iff (rst)
    (req.re && req.addr == `CFG_ADDR_VOLT) |=> rdata_q == $past(volt_ctl_q);
  endproperty
  a_read_volt: assert property (p_read_volt) else $error("volt readback wrong");

  property p_read_therm;
    @(posedge clk_sys) disable iff (rst)
    (req.re && req.addr == `CFG_ADDR_THERM) |=> rdata_q == $past(therm_ctl_q);
  endproperty
  a_read_therm: assert property (p_read_therm) else $error("therm readback wrong");

  property p_vreg_linear;
    @(posedge clk_sys) disable iff (rst)
    (volt_ctl_q[5:0] <= 6'h32) |=>
      setpoints_q.vreg_mv == 16'h0E10 + 16'h0014 * {10'h000, $past(volt_ctl_q[5:0])};
  endproperty
  a_vreg_linear: assert property (p_vreg_linear) else $error("regulation voltage step wrong");

  property p_fast_timer;
    @(posedge clk_sys) disable iff (rst)
    !timer_ctl_q.safety_timer_double |=>
      setpoints_q.fast_min == 12'h0B4 + 12'h078 * {10'h000, $past(timer_ctl_q.fast_charge_timer)};
  endproperty
  a_fast_timer: assert property (p_fast_timer) else $error("fast timer wrong");

  property p_fast_double;
    @(posedge clk_sys) disable iff (rst)
    timer_ctl_q.safety_timer_double |=>
      setpoints_q.fast_min == 12'h168 + 12'h0F0 * {10'h000, $past(timer_ctl_q.fast_charge_timer)};
  endproperty
  a_fast_double: assert property (p_fast_double) else $error("doubled fast timer wrong");

  property p_prequal_timer;
    @(posedge clk_sys) disable iff (rst)
    !timer_ctl_q.safety_timer_double |=>
      setpoints_q.prequal_min == 8'h0F + 8'h0F * {6'h00, $past(timer_ctl_q.prequal_charge_timer)};
  endproperty
  a_prequal_timer: assert property (p_prequal_timer) else $error("prequal timer wrong");

  property p_topoff;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> setpoints_q.topoff_tenth_min == 8'h40 * {6'h00, $past(timer_ctl_q.topoff_timer)};
  endproperty
  a_topoff: assert property (p_topoff) else $error("top-off timer wrong");

  property p_bias;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> setpoints_q.therm_ua == ($past(timer_ctl_q.thermistor_resistance_select) ? 7'h32 : 7'h05);
  endproperty
  a_bias: assert property (p_bias) else $error("thermistor bias wrong");

  property p_therm_step;
    @(posedge clk_sys) disable iff (rst)
    1'b1 |=> setpoints_q.therm_c == 8'h50 + 8'h05 * {5'h00, $past(therm_ctl_q[2:0])};
  endproperty
  a_therm_step: assert property (p_therm_step) else $error("thermal threshold step wrong");

  property p_beta_ends;
    @(posedge clk_sys) disable iff (rst)
    (therm_ctl_q[7:5] == 3'h0 |=> setpoints_q.beta == 16'h0D6A) and
    (therm_ctl_q[7:5] == 3'h7 |=> setpoints_q.beta == 16'h128E);
  endproperty
  a_beta_ends: assert property (p_beta_ends) else $error("beta end codes wrong");
endmodule // charger_config_registers

// *** tb/test_charger_config_registers.sv ***
`timescale 1ns/1ps
module test_charger_config_registers;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  charger_cfg_pkg::reg_req_t req = '0;
  logic charger_write_lock = 1'b0;
  logic [7:0] rdata_q, volt_ctl_q, therm_ctl_q;
  logic rvalid_q;
  charger_cfg_pkg::timer_fields_t timer_ctl_q;
  charger_cfg_pkg::charger_setpoints_t setpoints_q;
  int n_errors = 0;
  int check_count = 0;
  logic [7:0] rd_val;
  logic [15:0] beta_tab [8] = '{16'h0D6A, 16'h0E1A, 16'h0F5E, 16'h0F6E, 16'h1004, 16'h10D7, 16'h11BF, 16'h128E};
  always #4 clk_sys = ~clk_sys;
  charger_config_registers u_dut (.clk_sys(clk_sys), .rst(rst), .req(req), .charger_write_lock(charger_write_lock),
    .rdata_q(rdata_q), .rvalid_q(rvalid_q), .volt_ctl_q(volt_ctl_q), .timer_ctl_q(timer_ctl_q),
    .therm_ctl_q(therm_ctl_q), .setpoints_q(setpoints_q));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    req = '{we: 1'b1, re: 1'b0, addr: a, wdata: d};
    @(negedge clk_sys);
    req = '0;
    repeat (3) @(negedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge clk_sys);
    req = '{we: 1'b0, re: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk_sys);
    req = '0;
    chk("rvalid", 16'h0001, {15'h0000, rvalid_q});
    rd_val = rdata_q;
  endtask
  task automatic test_reset();
    rd(8'h15);
    chk("volt", 16'h001E, {8'h00, rd_val});
    rd(8'h16);
    chk("timer", 16'h0095, {8'h00, rd_val});
    rd(8'h17);
    chk("therm", 16'h0024, {8'h00, rd_val});
    rd(8'h18);
    chk("unmapped", 16'h0000, {8'h00, rd_val});
    chk("vreg", 16'h1068, setpoints_q.vreg_mv);
    chk("fast", 16'h012C, {4'h0, setpoints_q.fast_min});
    chk("prequal", 16'h001E, {8'h00, setpoints_q.prequal_min});
    chk("topoff", 16'h0040, {8'h00, setpoints_q.topoff_tenth_min});
    chk("beta", 16'h0E1A, setpoints_q.beta);
    chk("therm_c", 16'h0064, {8'h00, setpoints_q.therm_c});
    chk("restart", 16'h0FDC, setpoints_q.restart_mv);
    chk("bias", 16'h0032, {9'h000, setpoints_q.therm_ua});
  endtask
  task automatic test_lock();
    charger_write_lock = 1'b1;
    wr(8'h15, 8'h00);
    wr(8'h16, 8'h00);
    wr(8'h17, 8'h5A);
    chk("locked volt", 16'h001E, {8'h00, volt_ctl_q});
    chk("locked timer", 16'h0095, {8'h00, timer_ctl_q});
    chk("unlocked therm", 16'h005A, {8'h00, therm_ctl_q});
    rd(8'h16);
    chk("locked read", 16'h0095, {8'h00, rd_val});
    charger_write_lock = 1'b0;
    wr(8'h15, 8'h1F);
    chk("released volt", 16'h001F, {8'h00, volt_ctl_q});
  endtask
  task automatic test_voltage();
    logic [7:0] tab [4] = '{8'h00, 8'hB2, 8'h73, 8'h7F};
    logic [15:0] v, off;
    foreach (tab[i])
    begin
      wr(8'h15, tab[i]);
      v = 16'h0E10 + 16'h0014 * ((tab[i][5:0] > 6'h32) ? 16'h0032 : {10'h000, tab[i][5:0]});
      off = tab[i][6] ? 16'h00F0 : 16'h008C;
      chk("vreg", v, setpoints_q.vreg_mv);
      chk("restart", v - off, setpoints_q.restart_mv);
      rd(8'h15);
      chk("volt read", {8'h00, tab[i]}, {8'h00, rd_val});
    end
  endtask
  task automatic test_timer();
    logic [7:0] tab [6] = '{8'h00, 8'h55, 8'hAA, 8'hFF, 8'h66, 8'h71};
    logic [15:0] m;
    foreach (tab[i])
    begin
      wr(8'h16, tab[i]);
      m = tab[i][6] ? 16'h0002 : 16'h0001;
      chk("timer reg", {8'h00, tab[i]}, {8'h00, timer_ctl_q});
      chk("fast", (16'h00B4 + 16'h0078 * tab[i][5:4]) * m, {4'h0, setpoints_q.fast_min});
      chk("prequal", (16'h000F + 16'h000F * tab[i][3:2]) * m, {8'h00, setpoints_q.prequal_min});
      chk("topoff", 16'h0040 * tab[i][1:0], {8'h00, setpoints_q.topoff_tenth_min});
      chk("bias", tab[i][7] ? 16'h0032 : 16'h0005, {9'h000, setpoints_q.therm_ua});
    end
  endtask
  task automatic test_therm();
    logic [7:0] d;
    for (int i = 0; i < 8; i++)
    begin
      d = {i[2:0], 2'b11, 3'h7 - i[2:0]};
      wr(8'h17, d);
      chk("beta", beta_tab[i], setpoints_q.beta);
      chk("therm_c", 16'h0050 + 16'h0005 * (3'h7 - i[2:0]), {8'h00, setpoints_q.therm_c});
      rd(8'h17);
      chk("therm read", {8'h00, d}, {8'h00, rd_val});
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial
  begin
    #100000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 1'b0;
    repeat (3) @(negedge clk_sys);
    test_reset();
    test_lock();
    test_voltage();
    test_timer();
    test_therm();
    report_and_stop();
  end
endmodule // test_charger_config_registers
